// >>> tss_pkg.sv
// tss_pkg: shared constants for the trigger state sequencer
// assumes one sample per system clock; all configuration arrives as plain ports
package tss_pkg;

  // timing
  localparam longint CLK_HZ         = 20_000_000;
  localparam longint CNT_CLK_MAX_HZ = 250_000_000;
  localparam longint TIMER_MAX_S    = 2_000_000;
  localparam longint TIMER_MAX_CYC  = TIMER_MAX_S * CLK_HZ;

  // counter / timer pairs
  localparam int CT_W = 51;
  localparam int NCT  = 2;

  // internal system signals
  localparam int NSIG  = 4;
  localparam int SIG_W = 2;

  // resource budget
  localparam int              RES_MAX   = 16;
  localparam int              RS_W      = 6;
  localparam logic [RS_W-1:0] RES_ONE   = 6'h01;
  localparam logic [RS_W-1:0] RES_RANGE = 6'h03;

  // event index codes
  localparam int         EV_W      = 4;
  localparam int         NEV       = 16;
  localparam logic [3:0] EV_ANY    = 4'h0;
  localparam logic [3:0] EV_NONE   = 4'h1;
  localparam logic [3:0] EV_WORD   = 4'h2;
  localparam logic [3:0] EV_GEQ    = 4'h3;
  localparam logic [3:0] EV_GRNG   = 4'h4;
  localparam logic [3:0] EV_GCHG   = 4'h5;
  localparam logic [3:0] EV_CVAL   = 4'h6;
  localparam logic [3:0] EV_CCHG   = 4'h7;
  localparam logic [3:0] EV_TRANS  = 4'h8;
  localparam logic [3:0] EV_GLITCH = 4'h9;
  localparam logic [3:0] EV_SH     = 4'ha;
  localparam logic [3:0] EV_CT0    = 4'hb;
  localparam logic [3:0] EV_SIG    = 4'hd;

  // range recognizer operators
  localparam logic [2:0] RNG_LT  = 3'h0;
  localparam logic [2:0] RNG_LE  = 3'h1;
  localparam logic [2:0] RNG_GE  = 3'h2;
  localparam logic [2:0] RNG_GT  = 3'h3;
  localparam logic [2:0] RNG_IN  = 3'h4;
  localparam logic [2:0] RNG_OUT = 3'h5;

  // counter / timer actions
  localparam int         OP_W     = 3;
  localparam logic [2:0] CT_NOP   = 3'h0;
  localparam logic [2:0] CT_START = 3'h1;
  localparam logic [2:0] CT_STOP  = 3'h2;
  localparam logic [2:0] CT_RESET = 3'h3;
  localparam logic [2:0] CT_CLEAR = 3'h4;

  // clause word layout
  localparam int CL_A     = 0;
  localparam int CL_A_NEG = 4;
  localparam int CL_B     = 5;
  localparam int CL_B_NEG = 9;
  localparam int CL_OR    = 10;
  localparam int CL_GO    = 11;
  localparam int CL_TGT   = 12;
  localparam int TGT_W    = 3;
  localparam int CL_TRIG  = 15;
  localparam int CL_OP    = 16;
  localparam int CLW      = 22;

  // run control, gray coded
  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_GO   = 2'b01,
    RUN_HALT = 2'b11
  } tss_run_e;

endpackage : tss_pkg

// >>> tss_ct_unit.sv
// tss_ct_unit: one shared counter/timer, 51 bits, saturating
// assumes op is a one-cycle action code from the sequencer and the reset is synchronised
`timescale 1ns/1ps
module tss_ct_unit import tss_pkg::*; #(
  parameter int W = CT_W
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // control
  input  wire logic [2:0]   op_in,
  input  wire logic         timer_in,
  input  wire logic         cnt_ev_in,
  input  wire logic         gt_in,
  input  wire logic [W-1:0] lim_in,
  // compare result
  output logic              hit_out
);

  // a timer narrower than the longest time would saturate early
  if ((W > 62) || ((64'h1 << W) <= TIMER_MAX_CYC)) begin : g_bad_w
    $error("tss_ct_unit: W cannot hold the longest timer span");
  end

  logic         run_r, run_nxt;
  logic [W-1:0] val_r, val_nxt;

  // next value: count first, then the action overrides
  always_comb begin
    run_nxt = run_r;
    val_nxt = val_r;
    // saturate rather than wrap so a long span never looks short
    if (run_r && (timer_in || cnt_ev_in) && (val_r != '1)) begin
      val_nxt = val_r + W'(1);
    end
    unique case (op_in)
      CT_START: run_nxt = 1'b1;
      CT_STOP:  run_nxt = 1'b0;
      CT_RESET: val_nxt = '0;
      CT_CLEAR: begin
        val_nxt = '0;
        run_nxt = 1'b0;
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_r <= 1'b0;
      val_r <= '0;
    end else begin
      run_r <= run_nxt;
      val_r <= val_nxt;
    end
  end

  assign hit_out = gt_in ? (val_r > lim_in) : (val_r <= lim_in);

  a_clear_zeroes: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (op_in == CT_CLEAR) |=> (val_r == '0) && !run_r)
    else $error("clear did not zero and stop the unit");

  a_stopped_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!run_r && (op_in == CT_NOP)) |=> $stable(val_r) && !run_r)
    else $error("stopped unit changed value");

endmodule : tss_ct_unit

// >>> tss_trig_seq.sv
// tss_trig_seq: recognizers and state sequencer of an acquisition trigger
// assumes inputs synchronous to clk_sys_in, one sample per clock, config static while running
`timescale 1ns/1ps
// What this block does
// - word event compares all groups, one resource
// - group event: value, range or change
// - range six operators, three resources per group
// - group word equality, one resource per group
// - one change detector, barred under transitional storage
// - channel event tests level or change
// - transition event occurs or not, one resource
// - glitch only with internal clock
// - setup-hold fault only with external clock
// - at most sixteen resources, counters excluded
// - two 51-bit counters, two compare modes
// - two 51-bit timers up to two million seconds
// - counter and timer share one unit
// - one signal event from four system signals
// - always-true, no resource, not in OR
// - always-false, no resource, OR filler
// - clause combines events and runs actions
// - one go-to per clause changes state
// - clauses start, stop, reset, clear units
module tss_trig_seq import tss_pkg::*; #(
  parameter int NG  = 4,
  parameter int GW  = 8,
  parameter int NST = 8,
  parameter int NCL = 2
) (
  // clock and reset
  input  wire logic                      clk_sys_in,
  input  wire logic                      rst_n_in,
  // probed channels and front-end flags
  input  wire logic [NG*GW-1:0]          chan_in,
  input  wire logic [NG-1:0]             glitch_in,
  input  wire logic [NG-1:0]             sh_fault_in,
  input  wire logic [NSIG-1:0]           sys_sig_in,
  // run and clock mode
  input  wire logic                      run_in,
  input  wire logic                      clk_internal_in,
  input  wire logic                      store_trans_in,
  // word and group recognizers
  input  wire logic [NG*GW-1:0]          word_val_in,
  input  wire logic [NG*GW-1:0]          word_mask_in,
  input  wire logic [NG-1:0]             geq_mask_in,
  input  wire logic [GW-1:0]             geq_val_in,
  input  wire logic [NG-1:0]             rng_mask_in,
  input  wire logic [2:0]                rng_op_in,
  input  wire logic [GW-1:0]             rng_lo_in,
  input  wire logic [GW-1:0]             rng_hi_in,
  input  wire logic [NG-1:0]             chg_mask_in,
  // channel, transition, glitch, fault, signal
  input  wire logic [$clog2(NG*GW)-1:0]  chan_sel_in,
  input  wire logic                      chan_val_in,
  input  wire logic [NG*GW-1:0]          trans_mask_in,
  input  wire logic [NG*GW-1:0]          trans_from_in,
  input  wire logic [NG*GW-1:0]          trans_to_in,
  input  wire logic [NG-1:0]             glitch_mask_in,
  input  wire logic [NG-1:0]             sh_mask_in,
  input  wire logic [SIG_W-1:0]          sig_sel_in,
  // counter / timer units
  input  wire logic [NCT-1:0]            ct_timer_in,
  input  wire logic [NCT-1:0]            ct_gt_in,
  input  wire logic [NCT*EV_W-1:0]       ct_src_in,
  input  wire logic [NCT*CT_W-1:0]       ct_lim_in,
  // clause program
  input  wire logic [NST*NCL*CLW-1:0]    clause_cfg_in,
  // status
  output logic [TGT_W-1:0]               state_out,
  output logic                           trigger_out,
  output logic [NCL-1:0]                 clause_hit_out,
  output logic [RS_W-1:0]                res_used_out,
  output logic                           cfg_err_out,
  output logic                           running_out
);

  localparam int CH = NG * GW;

  if ((NST < 2) || (NST > (1 << TGT_W)) || (NCL < 1) || (GW < 1) || (NG < 1)
      || (NG > 4) || (CLK_HZ > CNT_CLK_MAX_HZ)) begin : g_bad_cfg
    $error("tss_trig_seq: parameters outside what the logic serves");
  end

  // reset release through two flops
  logic rst_s1_r, rst_s2_r, rst_n;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n = rst_s2_r;

  // range test for one group value
  function automatic logic rng_ok(input logic [GW-1:0] v, input logic [2:0] op,
                                  input logic [GW-1:0] lo, input logic [GW-1:0] hi);
    logic inr;
    inr = (v >= lo) && (v <= hi);
    unique case (op)
      RNG_LT:  rng_ok = v < lo;
      RNG_LE:  rng_ok = v <= lo;
      RNG_GE:  rng_ok = v >= lo;
      RNG_GT:  rng_ok = v > lo;
      RNG_IN:  rng_ok = inr;
      RNG_OUT: rng_ok = !inr;
      default: rng_ok = 1'b0;
    endcase
  endfunction : rng_ok

  logic [CH-1:0]   prev_r;
  logic [NEV-1:0]  ev;
  logic [NCT-1:0]  ct_hit;
  logic            eq_all, rng_all, chg_any;

  // recognizer evaluation on the current sample
  always_comb begin
    eq_all  = |geq_mask_in;
    rng_all = |rng_mask_in;
    chg_any = 1'b0;
    for (int i = 0; i < NG; i++) begin
      if (geq_mask_in[i] && (chan_in[i*GW +: GW] != geq_val_in)) eq_all = 1'b0;
      if (rng_mask_in[i] && !rng_ok(chan_in[i*GW +: GW], rng_op_in, rng_lo_in, rng_hi_in)) begin
        rng_all = 1'b0;
      end
      if (chg_mask_in[i] && (chan_in[i*GW +: GW] != prev_r[i*GW +: GW])) chg_any = 1'b1;
    end
    ev = '0;
    ev[EV_ANY] = 1'b1;
    ev[EV_NONE] = 1'b0;
    ev[EV_WORD] = ((chan_in ^ word_val_in) & word_mask_in) == '0;
    ev[EV_GEQ]  = eq_all;
    ev[EV_GRNG] = rng_all;
    ev[EV_GCHG] = chg_any;
    ev[EV_CVAL] = chan_in[chan_sel_in] == chan_val_in;
    ev[EV_CCHG] = chan_in[chan_sel_in] != prev_r[chan_sel_in];
    // every masked bit made its transition
    ev[EV_TRANS] = (|trans_mask_in) && ((trans_mask_in &
                   ((prev_r ^ trans_from_in) | (chan_in ^ trans_to_in))) == '0);
    ev[EV_GLITCH] = clk_internal_in && |(glitch_in & glitch_mask_in);
    ev[EV_SH] = !clk_internal_in && |(sh_fault_in & sh_mask_in);
    for (int k = 0; k < NCT; k++) ev[EV_CT0 + k] = ct_hit[k];
    ev[EV_SIG] = sys_sig_in[sig_sel_in];
  end

  logic [NEV-1:0]  used;
  logic [RS_W-1:0] res_sum;
  logic            or_any_err, tgt_err, cfg_err;
  logic [CLW-1:0]  cw;

  // resource usage over the whole program
  always_comb begin
    used       = '0;
    or_any_err = 1'b0;
    tgt_err    = 1'b0;
    cw         = '0;
    for (int c = 0; c < NST * NCL; c++) begin
      cw = clause_cfg_in[c*CLW +: CLW];
      used[cw[CL_A +: EV_W]] = 1'b1;
      used[cw[CL_B +: EV_W]] = 1'b1;
      if (cw[CL_OR] && ((cw[CL_A +: EV_W] == EV_ANY) || (cw[CL_B +: EV_W] == EV_ANY))) begin
        or_any_err = 1'b1;
      end
      if (cw[CL_GO] && (int'(cw[CL_TGT +: TGT_W]) >= NST)) tgt_err = 1'b1;
    end
    for (int k = 0; k < NCT; k++) used[ct_src_in[k*EV_W +: EV_W]] = 1'b1;
    res_sum = '0;
    for (int e = 0; e < NEV; e++) begin
      if (used[e] && (e >= int'(EV_WORD)) && (e < int'(EV_CT0))
          && (e != int'(EV_GEQ)) && (e != int'(EV_GRNG))) begin
        res_sum = res_sum + RES_ONE;
      end
    end
    res_sum = res_sum + (used[EV_SIG] ? RES_ONE : '0);
    for (int i = 0; i < NG; i++) begin
      if (used[EV_GEQ] && geq_mask_in[i]) res_sum = res_sum + RES_ONE;
      if (used[EV_GRNG] && rng_mask_in[i]) res_sum = res_sum + RES_RANGE;
    end
    cfg_err = or_any_err || tgt_err || (int'(res_sum) > RES_MAX)
              || (used[EV_GCHG] && used[EV_CCHG])
              || (store_trans_in && (used[EV_GCHG] || used[EV_CCHG]))
              || (used[EV_GLITCH] && !clk_internal_in)
              || (used[EV_SH] && clk_internal_in);
  end

  tss_run_e         run_r, run_nxt;
  logic [TGT_W-1:0] state_r, state_nxt;
  logic             trig_r, trig_nxt;
  logic [NCL-1:0]   hit, hit_r;
  logic [OP_W-1:0]  ct_op [NCT];
  logic             go_seen;
  logic [CLW-1:0]   sc;
  logic             ea, eb;

  // run control
  always_comb begin
    run_nxt = run_r;
    unique case (run_r)
      RUN_IDLE: if (run_in && !cfg_err) run_nxt = RUN_GO;
      RUN_GO:   if (!run_in) run_nxt = RUN_IDLE; else if (cfg_err) run_nxt = RUN_HALT;
      RUN_HALT: if (!run_in) run_nxt = RUN_IDLE;
      default:  run_nxt = RUN_IDLE;
    endcase
  end

  // clause evaluation in the current state
  always_comb begin
    state_nxt = state_r;
    trig_nxt  = 1'b0;
    hit       = '0;
    go_seen   = 1'b0;
    sc        = '0;
    ea        = 1'b0;
    eb        = 1'b0;
    for (int k = 0; k < NCT; k++) ct_op[k] = (run_r == RUN_GO) ? CT_NOP : CT_CLEAR;
    if (run_r != RUN_GO) begin
      // sequencer parks in the first state
      state_nxt = '0;
    end else begin
      for (int c = 0; c < NCL; c++) begin
        sc = clause_cfg_in[(int'(state_r) * NCL + c) * CLW +: CLW];
        ea = ev[sc[CL_A +: EV_W]] ^ sc[CL_A_NEG];
        eb = ev[sc[CL_B +: EV_W]] ^ sc[CL_B_NEG];
        hit[c] = sc[CL_OR] ? (ea || eb) : (ea && eb);
        if (hit[c]) begin
          if (sc[CL_TRIG]) trig_nxt = 1'b1;
          if (sc[CL_GO] && !go_seen) begin
            state_nxt = sc[CL_TGT +: TGT_W];
            go_seen   = 1'b1;
          end
          for (int k = 0; k < NCT; k++) begin
            if ((ct_op[k] == CT_NOP) && (sc[CL_OP + k*OP_W +: OP_W] != CT_NOP)) begin
              ct_op[k] = sc[CL_OP + k*OP_W +: OP_W];
            end
          end
        end
      end
    end
  end

  for (genvar k = 0; k < NCT; k++) begin : g_ct
    tss_ct_unit #(.W(CT_W)) u_ct (
      .clk_in    (clk_sys_in),
      .rst_n_in  (rst_n),
      .op_in     (ct_op[k]),
      .timer_in  (ct_timer_in[k]),
      .cnt_ev_in (!ct_timer_in[k] && ev[ct_src_in[k*EV_W +: EV_W]]),
      .gt_in     (ct_gt_in[k]),
      .lim_in    (ct_lim_in[k*CT_W +: CT_W]),
      .hit_out   (ct_hit[k])
    );
  end

  // registers move on the sample edge
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      run_r        <= RUN_IDLE;
      state_r      <= '0;
      trig_r       <= 1'b0;
      hit_r        <= '0;
      prev_r       <= '0;
      res_used_out <= '0;
      cfg_err_out  <= 1'b0;
      running_out  <= 1'b0;
    end else begin
      run_r        <= run_nxt;
      state_r      <= state_nxt;
      trig_r       <= trig_nxt;
      hit_r        <= hit;
      prev_r       <= chan_in;
      res_used_out <= res_sum;
      cfg_err_out  <= cfg_err;
      running_out  <= run_nxt == RUN_GO;
    end
  end

  assign state_out      = state_r;
  assign trigger_out    = trig_r;
  assign clause_hit_out = hit_r;

  a_idle_parks: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (run_r != RUN_GO) |=> (state_out == '0) && !trigger_out)
    else $error("state moved while not running");
  a_no_hit_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (run_r == RUN_GO && hit == '0) |=> $stable(state_out) && (clause_hit_out == '0))
    else $error("state changed with no clause true");
  a_glitch_sync: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (used[EV_GLITCH] && !clk_internal_in) |=> cfg_err_out)
    else $error("glitch with external clock not flagged");
  a_sh_async: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (used[EV_SH] && clk_internal_in) |=> cfg_err_out)
    else $error("setup-hold with internal clock not flagged");
  a_chg_trans: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (store_trans_in && (used[EV_GCHG] || used[EV_CCHG])) |=> cfg_err_out)
    else $error("change detector under transitional storage not flagged");
  a_res_budget: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (int'(res_sum) > RES_MAX) |=> cfg_err_out && (int'(res_used_out) > RES_MAX))
    else $error("resource overrun not flagged");
  a_any_or: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    or_any_err |=> cfg_err_out ##1 (run_r != RUN_GO || cfg_err))
    else $error("always-true in OR not flagged");
  a_trig_cause: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    trigger_out |-> $past(run_r) == RUN_GO && $past(hit) != '0)
    else $error("trigger without a true clause");

endmodule : tss_trig_seq

// >>> tss_sut_model.sv
// tss_sut_model: behavioural stand-in for the probed system under test
// assumes the bench seeds $urandom once; new values land just after each rising edge
`timescale 1ns/1ps
module tss_sut_model #(
  parameter int CW = 32,
  parameter int NG = 4
) (
  // clock
  input  wire logic          clk_in,
  // spread of channel values chosen by the bench
  input  wire logic [CW-1:0] span_in,
  // probed signals
  output logic [CW-1:0]      chan_out,
  output logic [NG-1:0]      glitch_out,
  output logic [NG-1:0]      fault_out,
  output logic [3:0]         sys_sig_out
);
  // quiet start so the first samples are defined
  initial begin
    chan_out    = '0;
    glitch_out  = '0;
    fault_out   = '0;
    sys_sig_out = '0;
  end

  // a narrow span keeps group values small, so equality and ranges hit often
  always @(posedge clk_in) begin
    chan_out    <= CW'($urandom) & span_in;
    glitch_out  <= NG'($urandom & $urandom); // sparse flags, both levels still seen
    fault_out   <= NG'($urandom & $urandom);
    sys_sig_out <= 4'($urandom);
  end
endmodule : tss_sut_model

// >>> tb_top.sv
// tb_top: self-checking bench for the trigger state sequencer
// assumes default sizes: 4 groups of 8 channels, 8 states, 2 clauses per state
`timescale 1ns/1ps
module tb_top import tss_pkg::*; ();
  // clock, reset and run control
  logic         clk_sys_in;
  logic         rst_n_in = 1'b0, run_in = 1'b0, clk_internal_in = 1'b1, store_trans_in = 1'b0;
  // channels and recognizer setup
  logic [31:0]  chan_in, span = 32'h03030303, word_val_in = '0, word_mask_in = 32'h0303;
  logic [31:0]  trans_mask_in = 32'h0101, trans_from_in = '0, trans_to_in = 32'h0101;
  logic [3:0]   glitch_in, sh_fault_in, sys_sig_in;
  logic [3:0]   geq_mask_in = 4'h5, rng_mask_in = 4'h3, chg_mask_in = 4'h3;
  logic [3:0]   glitch_mask_in = 4'h3, sh_mask_in = 4'hc;
  logic [7:0]   geq_val_in = 8'h2, rng_lo_in = 8'h1, rng_hi_in = 8'h2, ct_src_in = 8'h0;
  logic [2:0]   rng_op_in = 3'h0;
  logic [4:0]   chan_sel_in = 5'h0;
  logic         chan_val_in = 1'b0;
  logic [1:0]   sig_sel_in = 2'h0, ct_timer_in = 2'h1, ct_gt_in = 2'h3;
  logic [101:0] ct_lim_in = {51'h0, 51'h5};
  logic [351:0] clause_cfg_in = '0;
  // design status
  logic [2:0]   state_out;
  logic [1:0]   clause_hit_out;
  logic [5:0]   res_used_out;
  logic         trigger_out, cfg_err_out, running_out;
  int           err_total = 0, n_compared = 0;

  tss_sut_model i_tss_sut_model (.clk_in(clk_sys_in), .span_in(span), .chan_out(chan_in),
    .glitch_out(glitch_in), .fault_out(sh_fault_in), .sys_sig_out(sys_sig_in));

  tss_trig_seq i_tss_trig_seq (.clk_sys_in, .rst_n_in, .chan_in, .glitch_in, .sh_fault_in,
    .sys_sig_in, .run_in, .clk_internal_in, .store_trans_in, .word_val_in, .word_mask_in,
    .geq_mask_in, .geq_val_in, .rng_mask_in, .rng_op_in, .rng_lo_in, .rng_hi_in, .chg_mask_in,
    .chan_sel_in, .chan_val_in, .trans_mask_in, .trans_from_in, .trans_to_in, .glitch_mask_in,
    .sh_mask_in, .sig_sel_in, .ct_timer_in, .ct_gt_in, .ct_src_in, .ct_lim_in, .clause_cfg_in,
    .state_out, .trigger_out, .clause_hit_out, .res_used_out, .cfg_err_out, .running_out);

  // 20 MHz sample clock
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  // compare a value; case inequality so an unknown never matches
  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  // compare a single flag
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({63'h0, got}, {63'h0, exp});
  endtask : chk_bit

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // clause word: go_tgt is {go-to enable, target}
  function automatic logic [21:0] cl(input logic [3:0] a, input logic na, input logic [3:0] b,
      input logic orr, input logic [3:0] go_tgt, input logic trig, input logic [2:0] op0);
    return {3'h0, op0, trig, go_tgt[2:0], go_tgt[3], orr, 1'b0, b, na, a};
  endfunction : cl

  function automatic logic [21:0] ev1(input logic [3:0] a, input logic [3:0] b, input logic orr);
    return cl(a, 1'b0, b, orr, 4'h0, 1'b0, CT_NOP);
  endfunction : ev1

  // one write of the whole program, so the vector is driven once per step
  task automatic prog(input logic [21:0] s0c0, input logic [21:0] s0c1, input logic [21:0] s1c0);
    clause_cfg_in <= {286'h0, s1c0, s0c1, s0c0};
  endtask : prog

  function automatic logic in_rng(input logic [7:0] v);
    case (rng_op_in)
      RNG_LT:  return v < rng_lo_in;
      RNG_LE:  return v <= rng_lo_in;
      RNG_GE:  return v >= rng_lo_in;
      RNG_GT:  return v > rng_lo_in;
      RNG_IN:  return v >= rng_lo_in && v <= rng_hi_in;
      RNG_OUT: return !(v >= rng_lo_in && v <= rng_hi_in);
      default: return 1'b0;
    endcase
  endfunction : in_rng

  // expected event value from the current sample c and previous sample p
  function automatic logic ev_exp(input logic [3:0] e, input logic [31:0] c,
      input logic [31:0] p, input logic [3:0] gl, input logic [3:0] sh, input logic [3:0] sg);
    logic r;
    r = (e == EV_GEQ) ? |geq_mask_in : (e == EV_GRNG);
    for (int g = 0; g < 4; g++) begin
      if (e == EV_GEQ && geq_mask_in[g] && c[g*8+:8] != geq_val_in) r = 1'b0;
      if (e == EV_GRNG && rng_mask_in[g] && !in_rng(c[g*8+:8])) r = 1'b0;
      if (e == EV_GCHG && chg_mask_in[g] && c[g*8+:8] != p[g*8+:8]) r = 1'b1;
    end
    case (e)
      EV_ANY:    return 1'b1;
      EV_WORD:   return ((c ^ word_val_in) & word_mask_in) == 32'h0;
      EV_CVAL:   return c[chan_sel_in] == chan_val_in;
      EV_CCHG:   return c[chan_sel_in] != p[chan_sel_in];
      EV_TRANS:  return trans_mask_in != 32'h0 && ((p ^ trans_from_in) & trans_mask_in) == 32'h0
                   && ((c ^ trans_to_in) & trans_mask_in) == 32'h0;
      EV_GLITCH: return |(gl & glitch_mask_in) && clk_internal_in;
      EV_SH:     return |(sh & sh_mask_in) && !clk_internal_in;
      EV_SIG:    return sg[sig_sel_in];
      default:   return r;
    endcase
  endfunction : ev_exp

  function automatic logic [5:0] res_exp(input logic [3:0] e);
    case (e)
      EV_ANY, EV_NONE: return 6'h00;
      EV_GEQ:          return 6'($countones(geq_mask_in));
      EV_GRNG:         return 6'(3 * $countones(rng_mask_in));
      default:         return 6'h01;
    endcase
  endfunction : res_exp

  // one event as operand A, ANDed with anything or ORed with nothing, maybe negated
  task automatic run_ev(input logic [3:0] e, input logic [2:0] op);
    logic        orr, na, ex;
    logic [31:0] p, c;
    orr = (e != EV_ANY) && ($urandom_range(0, 1) == 1);
    na  = 1'($urandom);
    @(posedge clk_sys_in);
    run_in          <= 1'b0;
    rng_op_in       <= op;
    clk_internal_in <= (e != EV_SH);
    word_val_in     <= $urandom & span;
    geq_val_in      <= 8'($urandom_range(0, 3));
    chan_sel_in     <= {2'($urandom), 2'h0, 1'($urandom)};
    chan_val_in     <= 1'($urandom);
    trans_to_in     <= $urandom & 32'h0101;
    sig_sel_in      <= 2'($urandom);
    prog(cl(e, na, orr ? EV_NONE : EV_ANY, orr, 4'h0, 1'b1, CT_NOP), '0, '0);
    repeat (3) @(posedge clk_sys_in);
    #1;
    chk_val(res_used_out, res_exp(e));
    chk_bit(cfg_err_out, 1'b0);
    @(posedge clk_sys_in);
    run_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    p = chan_in;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_sys_in);
      c  = chan_in;
      ex = ev_exp(e, c, p, glitch_in, sh_fault_in, sys_sig_in) ^ na;
      p  = c;
      #1;
      chk_bit(trigger_out, ex);
      chk_bit(clause_hit_out[0], ex);
      chk_bit(clause_hit_out[1], 1'b1);
      chk_bit(running_out, 1'b1);
    end
  endtask : run_ev

  // program checked while idle; a bad one must keep the sequencer idle
  task automatic err_case(input logic [21:0] c0, input logic [21:0] c1, input logic ci,
      input logic st, input logic [5:0] res, input logic ex, input logic wide);
    @(posedge clk_sys_in);
    run_in          <= 1'b0;
    clk_internal_in <= ci;
    store_trans_in  <= st;
    geq_mask_in     <= wide ? 4'hf : 4'h5;
    rng_mask_in     <= wide ? 4'hf : 4'h3;
    prog(c0, c1, '0);
    repeat (3) @(posedge clk_sys_in);
    run_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    #1;
    chk_val(res_used_out, res);
    chk_bit(cfg_err_out, ex);
    chk_bit(running_out, !ex);
  endtask : err_case

  // unit 0 gets op in state 0; only start lets its compare (value > 5) trigger in state 1
  task automatic run_ct(input logic tm, input logic [3:0] src, input logic [2:0] op,
      input logic fire);
    int n;
    @(posedge clk_sys_in);
    run_in         <= 1'b0;
    store_trans_in <= 1'b0;
    ct_timer_in    <= {1'b0, tm};
    ct_src_in      <= {EV_ANY, src};
    prog(cl(EV_ANY, 1'b0, EV_ANY, 1'b0, 4'h9, 1'b0, op), '0,
         cl(EV_CT0, 1'b0, EV_ANY, 1'b0, 4'ha, 1'b1, CT_NOP));
    repeat (3) @(posedge clk_sys_in);
    run_in <= 1'b1;
    for (n = 0; n < 10 && state_out !== 3'h1; n++) begin
      @(posedge clk_sys_in);
      #1;
    end
    if (n == 10) begin
      err_total++;
      finish_test();
    end
    for (n = 1; n < 13; n++) begin
      @(posedge clk_sys_in);
      #1;
      if (trigger_out === 1'b1) break;
    end
    chk_bit(n >= 6 && n <= 8, fire);
    if (fire) chk_val(state_out, 3'h2);
    @(posedge clk_sys_in);
    run_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk_val({running_out, state_out}, 4'h0);
  endtask : run_ct

  // main sequence
  initial begin
    void'($urandom(69630));
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    #1;
    chk_val({state_out, trigger_out, clause_hit_out, res_used_out, cfg_err_out, running_out},
            64'h0);
    for (int e = 0; e < 14; e++) begin
      if (e == 4) for (int o = 0; o < 6; o++) run_ev(4'(e), 3'(o));
      else if (e != 11 && e != 12) run_ev(4'(e), RNG_LT);
    end
    err_case(ev1(EV_GLITCH, EV_ANY, 1'b0), '0, 1'b0, 1'b0, 6'h01, 1'b1, 1'b0);
    err_case(ev1(EV_GLITCH, EV_ANY, 1'b0), '0, 1'b1, 1'b0, 6'h01, 1'b0, 1'b0);
    err_case(ev1(EV_SH, EV_ANY, 1'b0), '0, 1'b1, 1'b0, 6'h01, 1'b1, 1'b0);
    err_case(ev1(EV_GCHG, EV_ANY, 1'b0), '0, 1'b1, 1'b1, 6'h01, 1'b1, 1'b0);
    err_case(ev1(EV_GCHG, EV_CCHG, 1'b0), '0, 1'b1, 1'b0, 6'h02, 1'b1, 1'b0);
    err_case(ev1(EV_ANY, EV_NONE, 1'b1), '0, 1'b1, 1'b0, 6'h00, 1'b1, 1'b0);
    err_case(ev1(EV_WORD, EV_ANY, 1'b0), ev1(EV_WORD, EV_NONE, 1'b1), 1'b1, 1'b0, 6'h01, 1'b0,
             1'b0);
    err_case(ev1(EV_GRNG, EV_GEQ, 1'b0), '0, 1'b1, 1'b0, 6'h10, 1'b0, 1'b1);
    err_case(ev1(EV_GRNG, EV_GEQ, 1'b0), ev1(EV_WORD, EV_ANY, 1'b0), 1'b1, 1'b0, 6'h11, 1'b1,
             1'b1);
    run_ct(1'b1, EV_NONE, CT_START, 1'b1);
    run_ct(1'b0, EV_ANY, CT_START, 1'b1);
    run_ct(1'b0, EV_NONE, CT_START, 1'b0);
    run_ct(1'b1, EV_NONE, CT_RESET, 1'b0);
    run_ct(1'b1, EV_NONE, CT_STOP, 1'b0);
    finish_test();
  end
endmodule : tb_top
